/* dcr_map.svh */
`ifndef DCR_MAP_SVH
`define DCR_MAP_SVH
// register byte addresses (word aligned)
`define DCR_GCTL_ADDR 8'h00
`define DCR_IRQ_STAT_ADDR 8'h04
`define DCR_IRQ_MASK_ADDR 8'h08
`define DCR_CH_BASE 8'h10
`define DCR_CH_STRIDE 8'h10
`define DCR_CH_CTL_OFS 2'h0
`define DCR_CH_SRC_OFS 2'h1
`define DCR_CH_DST_OFS 2'h2
`define DCR_CH_CNT_OFS 2'h3
// global control fields
`define DCR_G_NMI_BIT 0
`define DCR_G_ROT_BIT 1
`define DCR_G_FETCH_BIT 2
`define DCR_G_MASK 16'h0007
// channel control fields
`define DCR_C_REQ_BIT 0
`define DCR_C_ABORT_BIT 1
`define DCR_C_IE_BIT 2
`define DCR_C_DONE_BIT 3
`define DCR_C_EN_BIT 4
`define DCR_C_LEVEL_BIT 5
`define DCR_C_SBYTE_BIT 6
`define DCR_C_DBYTE_BIT 7
`define DCR_C_SSTEP_LO 8
`define DCR_C_DSTEP_LO 10
`define DCR_C_MODE_LO 12
`define DCR_C_MASK 16'h7fff
`define DCR_CTL_RESET 16'h0000
`define DCR_NUM_CH 3
`endif

/* dcr_pkg.sv */
package dcr_pkg;
  typedef enum logic [1:0] {DCR_IDLE = 2'b00, DCR_WAIT = 2'b01, DCR_MOVE = 2'b11} dcr_state_t;
  typedef logic [15:0] dcr_word_t;
endpackage : dcr_pkg

/* dcr_dma_regs.sv */
`timescale 1ns/100ps
`include "dcr_map.svh"
module dcr_dma_regs
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clkEn,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic [2:0] trigIn,
  input wire logic nmiIn,
  input wire logic fetchIn,
  input wire logic globalIrqEnable,
  input wire logic sysIrqIn,
  input wire logic moveDone,
  output logic moveReq,
  output logic [1:0] moveChan,
  output logic [15:0] moveSrcAddr,
  output logic [15:0] moveDstAddr,
  output logic moveSrcByte,
  output logic moveDstByte,
  output logic [2:0] moveMode,
  output logic sysIrqOut,
  output logic irqOut
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] s,
                                           input logic isByte);
    logic [15:0] d;
    d = isByte ? 16'h0001 : 16'h0002;
    case (s)
      2'h2: stepAddr = a - d;
      2'h3: stepAddr = a + d;
      default: stepAddr = a;
    endcase
  endfunction : stepAddr

  function automatic logic [1:0] pickChan(input logic [2:0] pend, input logic [1:0] first);
    logic [1:0] c;
    logic [2:0] t;
    pickChan = 2'h0;
    for (int k = 2; k >= 0; k--)
    begin
      // three bits so first + k cannot wrap before the modulo-3 fold
      t = {1'b0, first} + 3'(k);
      c = (t >= 3'h3) ? 2'(t - 3'h3) : 2'(t);
      if (pend[c])
        pickChan = c;
    end
  endfunction : pickChan

  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  dcr_word_t gctlReg, gctlNext;
  dcr_word_t ctlReg [3], ctlNext [3];
  dcr_word_t srcReg [3], srcNext [3];
  dcr_word_t dstReg [3], dstNext [3];
  dcr_word_t cntReg [3], cntNext [3];
  dcr_word_t loadReg [3], loadNext [3];
  dcr_word_t wSrcReg [3], wSrcNext [3];
  dcr_word_t wDstReg [3], wDstNext [3];
  logic [2:0] trigPrevReg, trigPrevNext;
  logic [2:0] pendReg, pendNext;
  logic [2:0] statReg, statNext;
  logic [2:0] maskReg, maskNext;
  logic [1:0] firstReg, firstNext;
  logic [1:0] chanReg, chanNext;
  logic haltReg, haltNext;
  dcr_state_t stateReg, stateNext;
  logic [31:0] rdReg, rdNext;
  logic waitReg, waitNext;
  logic irqReg, irqNext;
  logic sysReg, sysNext;
  logic moveReqReg, moveReqNext;
  dcr_word_t mSrcReg, mSrcNext, mDstReg, mDstNext;
  logic [4:0] mUnitReg, mUnitNext;

  logic access;
  logic [1:0] chSel, fld;
  logic chHit;
  logic [2:0] want;
  logic [2:0] doneEv;

  assign access = (avsRead | avsWrite) & waitReg;
  assign chSel = 2'((avsAddress - `DCR_CH_BASE) >> 4);
  assign fld = avsAddress[3:2];
  assign chHit = avsAddress >= `DCR_CH_BASE && avsAddress < 8'h40;

  // --------------------------------------------------------------
  // next state
  // --------------------------------------------------------------
  always_comb
  begin
    gctlNext = gctlReg;
    statNext = statReg;
    maskNext = maskReg;
    trigPrevNext = trigIn;
    pendNext = pendReg;
    firstNext = firstReg;
    chanNext = chanReg;
    haltNext = haltReg;
    stateNext = stateReg;
    rdNext = rdReg;
    waitNext = 1'b1;
    doneEv = 3'h0;
    want = 3'h0;
    for (int i = 0; i < 3; i++)
    begin
      ctlNext[i] = ctlReg[i];
      srcNext[i] = srcReg[i];
      dstNext[i] = dstReg[i];
      cntNext[i] = cntReg[i];
      loadNext[i] = loadReg[i];
      wSrcNext[i] = wSrcReg[i];
      wDstNext[i] = wDstReg[i];
      if (ctlReg[i][`DCR_C_EN_BIT] && cntReg[i] != 16'h0000 && !haltReg)
      begin
        if (ctlReg[i][`DCR_C_LEVEL_BIT])
          want[i] = trigIn[i];
        else
          want[i] = trigIn[i] & ~trigPrevReg[i];
        if (ctlReg[i][`DCR_C_REQ_BIT])
          want[i] = 1'b1;
      end
      ctlNext[i][`DCR_C_REQ_BIT] = 1'b0;
      if (want[i])
        pendNext[i] = 1'b1;
      if (!ctlReg[i][`DCR_C_EN_BIT])
        pendNext[i] = 1'b0;
    end
    // mover sequencing
    case (stateReg)
      DCR_IDLE:
        if (pendReg != 3'h0 && !haltReg)
        begin
          chanNext = gctlReg[`DCR_G_ROT_BIT] ? pickChan(pendReg, firstReg)
                                             : pickChan(pendReg, 2'h0);
          stateNext = gctlReg[`DCR_G_FETCH_BIT] ? DCR_WAIT : DCR_MOVE;
        end
      DCR_WAIT:
        if (fetchIn)
          stateNext = DCR_MOVE;
      DCR_MOVE:
        if (moveDone)
        begin
          stateNext = DCR_IDLE;
          wSrcNext[chanReg] = stepAddr(wSrcReg[chanReg], ctlReg[chanReg][9:8],
                                       ctlReg[chanReg][`DCR_C_SBYTE_BIT]);
          wDstNext[chanReg] = stepAddr(wDstReg[chanReg], ctlReg[chanReg][11:10],
                                       ctlReg[chanReg][`DCR_C_DBYTE_BIT]);
          // a trigger seen in the finishing cycle stays pending
          pendNext[chanReg] = want[chanReg];
          firstNext = (chanReg == 2'h2) ? 2'h0 : 2'(chanReg + 2'h1);
          if (cntReg[chanReg] == 16'h0001)
          begin
            cntNext[chanReg] = loadReg[chanReg];
            wSrcNext[chanReg] = srcReg[chanReg];
            wDstNext[chanReg] = dstReg[chanReg];
            doneEv[chanReg] = 1'b1;
          end
          else
            cntNext[chanReg] = 16'(cntReg[chanReg] - 16'h0001);
          if (gctlReg[`DCR_G_NMI_BIT] && nmiIn)
          begin
            haltNext = 1'b1;
            ctlNext[chanReg][`DCR_C_ABORT_BIT] = 1'b1;
          end
        end
      default:
        stateNext = DCR_IDLE;
    endcase
    // bus slave: one wait cycle, then answer
    if (access)
    begin
      waitNext = 1'b0;
      rdNext = 32'h0000_0000;
      if (avsAddress == `DCR_GCTL_ADDR)
      begin
        rdNext[15:0] = gctlReg;
        if (avsWrite)
        begin
          gctlNext = avsWriteData[15:0] & `DCR_G_MASK;
          haltNext = 1'b0;
        end
      end
      else if (avsAddress == `DCR_IRQ_STAT_ADDR)
      begin
        rdNext[2:0] = statReg;
        if (avsRead)
          statNext = 3'h0; // read clears
      end
      else if (avsAddress == `DCR_IRQ_MASK_ADDR)
      begin
        rdNext[2:0] = maskReg;
        if (avsWrite)
          maskNext = avsWriteData[2:0];
      end
      else if (chHit && avsAddress[1:0] == 2'h0)
      begin
        case (fld)
          `DCR_CH_CTL_OFS: rdNext[15:0] = ctlReg[chSel];
          `DCR_CH_SRC_OFS: rdNext[15:0] = srcReg[chSel];
          `DCR_CH_DST_OFS: rdNext[15:0] = dstReg[chSel];
          default: rdNext[15:0] = cntReg[chSel];
        endcase
        if (avsWrite)
          case (fld)
            `DCR_CH_CTL_OFS:
            begin
              ctlNext[chSel] = avsWriteData[15:0] & `DCR_C_MASK;
              if (doneEv[chSel])
                ctlNext[chSel][`DCR_C_DONE_BIT] = 1'b1;
              if (!avsWriteData[`DCR_C_EN_BIT])
                pendNext[chSel] = 1'b0;
            end
            `DCR_CH_SRC_OFS:
            begin
              srcNext[chSel] = avsWriteData[15:0];
              wSrcNext[chSel] = avsWriteData[15:0];
            end
            `DCR_CH_DST_OFS:
            begin
              dstNext[chSel] = avsWriteData[15:0];
              wDstNext[chSel] = avsWriteData[15:0];
            end
            default:
            begin
              cntNext[chSel] = avsWriteData[15:0];
              loadNext[chSel] = avsWriteData[15:0];
            end
          endcase
      end
    end
    for (int i = 0; i < 3; i++)
      if (doneEv[i])
      begin
        ctlNext[i][`DCR_C_DONE_BIT] = 1'b1;
        statNext[i] = 1'b1;
      end
    irqNext = 1'b0;
    for (int i = 0; i < 3; i++)
      if ((ctlNext[i][`DCR_C_DONE_BIT] && ctlNext[i][`DCR_C_IE_BIT] && globalIrqEnable)
          || (statNext[i] && maskNext[i]))
        irqNext = 1'b1;
    sysNext = sysIrqIn && (stateNext == DCR_IDLE);
    // unit descriptor registered from next state so outputs leave flops
    moveReqNext = (stateNext == DCR_MOVE);
    mSrcNext = wSrcNext[chanNext];
    mDstNext = wDstNext[chanNext];
    mUnitNext = {ctlNext[chanNext][14:12], ctlNext[chanNext][`DCR_C_SBYTE_BIT],
                 ctlNext[chanNext][`DCR_C_DBYTE_BIT]};
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gctlReg <= 16'h0000;
      statReg <= 3'h0;
      maskReg <= 3'h0;
      trigPrevReg <= 3'h0;
      pendReg <= 3'h0;
      firstReg <= 2'h0;
      chanReg <= 2'h0;
      haltReg <= 1'b0;
      stateReg <= DCR_IDLE;
      rdReg <= 32'h0000_0000;
      waitReg <= 1'b1;
      irqReg <= 1'b0;
      sysReg <= 1'b0;
      moveReqReg <= 1'b0;
      mSrcReg <= 16'h0000;
      mDstReg <= 16'h0000;
      mUnitReg <= 5'h00;
      for (int i = 0; i < 3; i++)
      begin
        ctlReg[i] <= `DCR_CTL_RESET;
        srcReg[i] <= 16'h0000;
        dstReg[i] <= 16'h0000;
        cntReg[i] <= 16'h0000;
        loadReg[i] <= 16'h0000;
        wSrcReg[i] <= 16'h0000;
        wDstReg[i] <= 16'h0000;
      end
    end
    else if (clkEn)
    begin
      gctlReg <= gctlNext;
      statReg <= statNext;
      maskReg <= maskNext;
      trigPrevReg <= trigPrevNext;
      pendReg <= pendNext;
      firstReg <= firstNext;
      chanReg <= chanNext;
      haltReg <= haltNext;
      stateReg <= stateNext;
      rdReg <= rdNext;
      waitReg <= waitNext;
      irqReg <= irqNext;
      sysReg <= sysNext;
      moveReqReg <= moveReqNext;
      mSrcReg <= mSrcNext;
      mDstReg <= mDstNext;
      mUnitReg <= mUnitNext;
      for (int i = 0; i < 3; i++)
      begin
        ctlReg[i] <= ctlNext[i];
        srcReg[i] <= srcNext[i];
        dstReg[i] <= dstNext[i];
        cntReg[i] <= cntNext[i];
        loadReg[i] <= loadNext[i];
        wSrcReg[i] <= wSrcNext[i];
        wDstReg[i] <= wDstNext[i];
      end
    end
  end

  // mover outputs are registered state or fields of it
  assign avsReadData = rdReg;
  assign avsWaitRequest = waitReg;
  assign moveReq = moveReqReg;
  assign moveChan = chanReg;
  assign moveSrcAddr = mSrcReg;
  assign moveDstAddr = mDstReg;
  assign moveSrcByte = mUnitReg[1];
  assign moveDstByte = mUnitReg[0];
  assign moveMode = mUnitReg[4:2];
  assign irqOut = irqReg;
  assign sysIrqOut = sysReg;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_req_self_clear: assert property (clkEn |=> !ctlReg[0][0] || $past(access))
    else $error("soft request not cleared");
  chk_cnt_dec: assert property (clkEn && stateReg == DCR_MOVE && moveDone
    && cntReg[chanReg] > 16'h0001 && !access |=> cntReg[$past(chanReg)]
    == $past(cntReg[chanReg]) - 16'h0001)
    else $error("count did not decrement");
  chk_cnt_reload: assert property (clkEn && stateReg == DCR_MOVE && moveDone
    && cntReg[chanReg] == 16'h0001 && !access |=> cntReg[$past(chanReg)]
    == loadReg[$past(chanReg)])
    else $error("count not reloaded");
  chk_done_set: assert property (clkEn && stateReg == DCR_MOVE && moveDone
    && cntReg[chanReg] == 16'h0001 |=> ctlReg[$past(chanReg)][3] && statReg[$past(chanReg)])
    else $error("done flag not set");
  chk_src_kept: assert property (clkEn && !access |=> srcReg[0] == $past(srcReg[0]))
    else $error("source register changed");
  chk_dst_kept: assert property (clkEn && !access |=> dstReg[1] == $past(dstReg[1]))
    else $error("dest register changed");
  chk_halt_nmi: assert property (clkEn && stateReg == DCR_MOVE && moveDone && nmiIn
    && gctlReg[0] && !access |=> haltReg ##1 (stateReg != DCR_MOVE))
    else $error("nmi did not halt");
  chk_disabled_idle: assert property (clkEn && !ctlReg[0][4] |=> !pendReg[0])
    else $error("disabled channel pending");
  chk_sys_held: assert property (clkEn && moveReq && !moveDone |=> !sysIrqOut)
    else $error("system irq leaked");
  chk_fixed_prio: assert property (clkEn && stateReg == DCR_IDLE && !gctlReg[1] && pendReg[0]
    && !haltReg |=> chanReg == 2'h0)
    else $error("fixed priority broken");
  chk_fetch_wait: assert property (clkEn && stateReg == DCR_WAIT && !fetchIn
    |=> stateReg == DCR_WAIT)
    else $error("fetch wait skipped");
  chk_zero_cnt: assert property (clkEn && cntReg[2] == 16'h0000 && !pendReg[2]
    |=> !pendReg[2] || $past(access))
    else $error("zero count started transfer");

  cov_move: cover property (stateReg == DCR_MOVE && moveDone);
  cov_reload: cover property (stateReg == DCR_MOVE && moveDone && cntReg[chanReg] == 16'h0001);
  cov_abort: cover property (haltReg);
  cov_irq: cover property (irqOut);

endmodule : dcr_dma_regs

/* dcr_mover_model.sv */
`timescale 1ns/100ps
module dcr_mover_model
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic moveReq,
  input wire logic slow,
  output logic moveDone
);
  logic [2:0] waitReg, waitNext;
  logic doneNext;
  // ----
  // unit mover: answers each request once
  // ----
  // slow mode stalls four cycles so the engine sees a busy memory side
  always_comb
  begin
    waitNext = 3'h0;
    doneNext = 1'b0;
    if (moveReq && !moveDone)
    begin
      doneNext = !slow || (waitReg == 3'h4);
      waitNext = doneNext ? 3'h0 : waitReg + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitReg <= 3'h0;
      moveDone <= 1'b0;
    end
    else
    begin
      waitReg <= waitNext;
      moveDone <= doneNext;
    end
  end
endmodule : dcr_mover_model

/* dcr_dma_regs_tb.sv */
`timescale 1ns/100ps
`include "dcr_map.svh"
module dcr_dma_regs_tb
  import dcr_pkg::*;
;
  logic clk, arst_n, avsRead, avsWrite, avsWaitRequest, nmiIn, fetchIn, global_irq_enable;
  logic sysIrqIn, moveDone, moveReq, moveSrcByte, moveDstByte, sysIrqOut, irqOut, slow, clkEn;
  logic [7:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData;
  logic [2:0] trigIn, moveMode;
  logic [1:0] moveChan;
  dcr_word_t moveSrcAddr, moveDstAddr, s, d, q;
  int badCount, testsRun, seed, n0;
  int moves[3];

  dcr_dma_regs i_dcr_dma_regs (.clk, .arst_n, .clkEn, .avsAddress, .avsRead,
    .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .trigIn, .nmiIn, .fetchIn,
    .globalIrqEnable(global_irq_enable), .sysIrqIn, .moveDone, .moveReq, .moveChan, .moveSrcAddr,
    .moveDstAddr, .moveSrcByte, .moveDstByte, .moveMode, .sysIrqOut, .irqOut);
  dcr_mover_model i_dcr_mover_model (.clk, .arst_n, .moveReq, .slow, .moveDone);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (moveReq === 1'b1 && moveDone === 1'b1)
      moves[moveChan] <= moves[moveChan] + 1;

  // ----
  // shared tasks
  // ----
  task automatic testDone();
    if (badCount == 0 && testsRun > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : testDone
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    testsRun++;
    if (got !== exp)
    begin
      badCount++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic bus(input logic wr, input logic [7:0] a, input dcr_word_t v);
    int n;
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= {16'h0000, v};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avsWaitRequest !== 1'b0 && n < 20);
    if (avsWaitRequest !== 1'b0)
    begin
      badCount++;
      testDone();
    end
    q = avsReadData[15:0];
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input dcr_word_t v);
    bus(1'b1, a, v);
  endtask : wr
  task automatic rd(input string what, input logic [7:0] a, input dcr_word_t e,
    input dcr_word_t m = 16'hffff);
    bus(1'b0, a, 16'h0000);
    chk(what, e, q & m);
  endtask : rd
  function automatic logic [7:0] ca(input int ch, input logic [1:0] ofs);
    return 8'(`DCR_CH_BASE + `DCR_CH_STRIDE * ch) + {4'h0, ofs, 2'b00};
  endfunction : ca
  task automatic waitMove(input logic level);
    int n;
    n = 0;
    while (moveReq !== level && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    if (moveReq !== level)
    begin
      badCount++;
      testDone();
    end
  endtask : waitMove
  task automatic mv(input logic [1:0] ch, input dcr_word_t sa, input dcr_word_t da,
    input logic [4:0] ext);
    waitMove(1'b1);
    chk("moveChan", ch, moveChan);
    chk("moveSrcAddr", sa, moveSrcAddr);
    chk("moveDstAddr", da, moveDstAddr);
    chk("moveUnit", ext, {moveMode, moveSrcByte, moveDstByte});
    chk("sysIrqOut", 1'b0, sysIrqOut);
    waitMove(1'b0);
  endtask : mv

  // ----
  // main sequence
  // ----
  initial
  begin
    seed = 35018;
    {arst_n, avsRead, avsWrite, nmiIn, fetchIn, global_irq_enable, sysIrqIn, slow} = '0;
    avsAddress = 8'h00;
    avsWriteData = 32'h0000_0000;
    trigIn = 3'h0;
    clkEn = 1'b1;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    rd("globalCtl", `DCR_GCTL_ADDR, 16'h0000);
    rd("ctl0", ca(0, 0), `DCR_CTL_RESET);
    wr(`DCR_GCTL_ADDR, 16'hffff);
    rd("globalCtl", `DCR_GCTL_ADDR, `DCR_G_MASK);
    wr(`DCR_GCTL_ADDR, 16'h0000);
    wr(ca(2, 0), 16'hffee);
    rd("ctl2", ca(2, 0), 16'h7fee);
    wr(ca(2, 0), 16'h0000);
    rd("unmapped", 8'hfc, 16'h0000);
    // software request, two word units, slow memory side
    s = 16'($random(seed));
    d = 16'($random(seed));
    slow <= 1'b1;
    global_irq_enable <= 1'b1;
    sysIrqIn <= 1'b1;
    wr(ca(0, 1), s);
    wr(ca(0, 2), d);
    wr(ca(0, 3), 16'h0002);
    wr(ca(0, 0), 16'h0f15);
    mv(2'd0, s, d, 5'h00);
    rd("ctl0", ca(0, 0), 16'h0f14);
    rd("count0", ca(0, 3), 16'h0001);
    wr(ca(0, 0), 16'h0f15);
    mv(2'd0, s + 16'h0002, d + 16'h0002, 5'h00);
    rd("src0", ca(0, 1), s);
    rd("dst0", ca(0, 2), d);
    rd("count0", ca(0, 3), 16'h0002);
    rd("ctl0", ca(0, 0), 16'h0f1c);
    chk("irqOut", 1'b1, irqOut);
    chk("sysIrqOut", 1'b1, sysIrqOut);
    wr(ca(0, 0), 16'h0f14);
    @(posedge clk);
    chk("irqOut", 1'b0, irqOut);
    wr(`DCR_IRQ_MASK_ADDR, 16'h0007);
    @(posedge clk);
    chk("irqOut", 1'b1, irqOut);
    rd("status", `DCR_IRQ_STAT_ADDR, 16'h0001);
    rd("status", `DCR_IRQ_STAT_ADDR, 16'h0000);
    @(posedge clk);
    chk("irqOut", 1'b0, irqOut);
    // byte units, edge trigger held high, fixed source, stepping-down dest
    slow <= 1'b0;
    s = 16'($random(seed));
    d = 16'($random(seed));
    wr(ca(1, 1), s);
    wr(ca(1, 2), d);
    wr(ca(1, 3), 16'h0002);
    wr(ca(1, 0), 16'h58d0);
    trigIn <= 3'b010;
    mv(2'd1, s, d, 5'h17);
    repeat (20) @(posedge clk);
    chk("moves1", 1, moves[1]);
    trigIn <= 3'b000;
    @(posedge clk);
    trigIn <= 3'b010;
    mv(2'd1, s, d - 16'h0001, 5'h17);
    trigIn <= 3'b000;
    rd("count1", ca(1, 3), 16'h0002);
    // zero count, disabled channel, then level trigger
    wr(ca(2, 3), 16'h0000);
    wr(ca(2, 0), 16'h0030);
    trigIn <= 3'b100;
    repeat (20) @(posedge clk);
    chk("moves2", 0, moves[2]);
    wr(ca(2, 0), 16'h0020);
    wr(ca(2, 3), 16'h0003);
    repeat (20) @(posedge clk);
    chk("moves2", 0, moves[2]);
    wr(ca(2, 0), 16'h0030);
    repeat (40) @(posedge clk);
    trigIn <= 3'b000;
    chk("levelRepeat", 1'b1, moves[2] > 1);
    repeat (8) @(posedge clk);
    // two channels at once, fixed then rotating order
    wr(ca(0, 0), 16'h0f10);
    trigIn <= 3'b011;
    waitMove(1'b1);
    chk("moveChan", 2'd0, moveChan);
    trigIn <= 3'b000;
    wr(`DCR_GCTL_ADDR, 16'h0002);
    repeat (8) @(posedge clk);
    n0 = moves[0] + moves[1];
    trigIn <= 3'b011;
    repeat (40) @(posedge clk);
    trigIn <= 3'b000;
    chk("rotateMoves", n0 + 2, moves[0] + moves[1]);
    @(posedge clk);
    trigIn <= 3'b001;
    waitMove(1'b1);
    trigIn <= 3'b000;
    waitMove(1'b0);
    trigIn <= 3'b011;
    waitMove(1'b1);
    chk("rotateChan", 2'd1, moveChan);
    trigIn <= 3'b000;
    waitMove(1'b0);
    repeat (8) @(posedge clk);
    // nmi during a unit, then fetch-aligned start
    slow <= 1'b1;
    wr(`DCR_GCTL_ADDR, 16'h0001);
    wr(ca(0, 0), 16'h0f11);
    waitMove(1'b1);
    nmiIn <= 1'b1;
    waitMove(1'b0);
    nmiIn <= 1'b0;
    rd("abort0", ca(0, 0), 16'h0002, 16'h0003);
    n0 = moves[0];
    wr(ca(0, 0), 16'h0f11);
    repeat (20) @(posedge clk);
    chk("haltMoves", n0, moves[0]);
    wr(`DCR_GCTL_ADDR, 16'h0004);
    wr(ca(0, 0), 16'h0f11);
    repeat (10) @(posedge clk);
    chk("moveReq", 1'b0, moveReq);
    fetchIn <= 1'b1;
    @(posedge clk);
    fetchIn <= 1'b0;
    waitMove(1'b1);
    waitMove(1'b0);
    // frozen engine holds its edge detector and starts nothing
    wr(`DCR_GCTL_ADDR, 16'h0000);
    n0 = moves[1];
    clkEn <= 1'b0;
    trigIn <= 3'b010;
    repeat (10) @(posedge clk);
    chk("frozenMoves", n0, moves[1]);
    chk("frozenReq", 1'b0, moveReq);
    clkEn <= 1'b1;
    waitMove(1'b1);
    chk("moveChan", 2'd1, moveChan);
    trigIn <= 3'b000;
    waitMove(1'b0);
    testDone();
  end
endmodule : dcr_dma_regs_tb
